/* File: include/pwr_seq_pkg.sv */
// Constants and state types for the power, reset and wake sequencer
package pwr_seq_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int WDOG_TIME_MS = 4000;
  localparam int WDOG_CYCLES_DEF = CLK_HZ / 1000 * WDOG_TIME_MS;
  localparam int KA_CYCLES_DEF = 100000;
  localparam int RTC_DIV = 763;
  localparam logic [3:0] BATT_SAMPLE_TICKS = 4'h4;
  localparam int WAKE_GPIO_N = 8;
  localparam int WAKE_GPIO3 = 3;
  localparam logic [7:0] WAKE_EN_RESET = 8'h00;
  localparam logic [3:0] PERI_HOLD = 4'h4;
  localparam logic [3:0] CORE_HOLD = 4'h8;
  localparam int ST_RTC_RESET = 0;
  localparam int ST_RESET_SWITCH = 1;
  localparam int ST_TIMEOUT = 2;
  localparam int ST_KEEPALIVE = 3;
  localparam int ST_BATT_INHIBIT = 4;
  localparam int ST_CARRIER = 5;
  localparam int ST_GPIO_LSB = 8;
  localparam int ST_W = 16;

  typedef enum logic [5:0] {
    S_OFF = 6'h01,
    S_ANNOUNCE = 6'h02,
    S_PERI_REL = 6'h04,
    S_CORE_REL = 6'h08,
    S_RUN = 6'h10,
    S_SHUT = 6'h20
  } seq_state_e;
endpackage : pwr_seq_pkg

/* File: hdl/pin_sync3.sv */
// Three-stage input synchroniser, output changes when stages two and three agree
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r, s2_r, s3_r;
  logic [W-1:0] q_nxt;
  assign q_nxt = (s2_r & s3_r) | (~(s2_r ^ s3_r) & s2_r) | ((s2_r ^ s3_r) & q);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q <= INIT;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q <= q_nxt;
    end
  end
endmodule : pin_sync3

/* File: hdl/power_reset_wake_sequencer.sv */
// Power, reset and wake sequencer top
// Contract
// RULE_01: RTC reset resets all, sets flag
// RULE_02: Cause flags hold until software clears
// RULE_03: Reset switch resets peripherals, core, sets flag
// RULE_04: Software clears activation watchdog within four seconds
// RULE_05: Watchdog expiry resets core, sets timeout flag
// RULE_06: Keep-alive expiry resets core, sets flag
// RULE_07: Software clears keep-alive counter each interval
// RULE_08: Deep sleep only without pending interrupts
// RULE_09: Shutdowns keep RTC, reset peripherals, core
// RULE_10: Twelve wake sources; battery low blocks
// RULE_11: Power-on indication brackets battery inhibit sample
// RULE_12: Inhibit high: release peripherals, then core
// RULE_13: Inhibit low: set flag, shut down again
// RULE_14: GPIO wakes only when enabled
// RULE_15: RTC reset clears enables; line three falls
// RULE_16: GPIO wake flag set regardless of outcome
// RULE_17: Carrier bit shows live pin level
// RULE_18: Inhibit sampled fixed RTC ticks after rise
`timescale 1ns/100ps
module power_reset_wake_sequencer import pwr_seq_pkg::*; #(
  parameter int WDOG_CYCLES = WDOG_CYCLES_DEF,
  parameter int KA_CYCLES = KA_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic rtc_reset_in_n,
  input wire logic reset_switch_in_n,
  input wire logic power_switch_in,
  input wire logic [WAKE_GPIO_N-1:0] gpio_wake_in,
  input wire logic carrier_detect_in_n,
  input wire logic touch_wake_in,
  input wire logic alarm_wake_in,
  input wire logic battery_inhibit_in,
  input wire logic battery_low_in,
  input wire logic [WAKE_GPIO_N-1:0] wake_enable_wdata,
  input wire logic wake_enable_we,
  input wire logic activation_watchdog_clear,
  input wire logic keepalive_enable,
  input wire logic keepalive_counter_clear,
  input wire logic software_shutdown_req,
  input wire logic irq_pending,
  input wire logic [ST_W-1:0] status_clear,
  output logic power_on_indication,
  output logic main_power_enable_out,
  output logic rtc_reset_out,
  output logic peripheral_reset_out,
  output logic core_cold_reset_out,
  output logic core_reset_out,
  output logic cpu_clock_stop,
  output logic [WAKE_GPIO_N-1:0] wake_enable,
  output logic [ST_W-1:0] power_status_register
);
  logic rst_a_r, rst_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_a_r <= 1'b0;
      rst_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_r <= rst_a_r;
    end
  end

  localparam int NPIN = 13;
  logic [NPIN-1:0] pin_q;
  logic rtc_rst_n_s, rsw_n_s, pwr_s, dcd_n_s, touch_s, alarm_s, batt_inh_s, batt_low_s;
  logic [WAKE_GPIO_N-1:0] gpio_s;
  // Reset values match each pin's idle level so that no false edge follows reset
  pin_sync3 #(.W(NPIN + WAKE_GPIO_N - 8), .INIT(13'h1a00)) u_sync (
    .clk(clk),
    .rst_n(rst_r),
    .d({rtc_reset_in_n, reset_switch_in_n, power_switch_in, carrier_detect_in_n, touch_wake_in,
        alarm_wake_in, battery_inhibit_in, battery_low_in, gpio_wake_in[7:3]}),
    .q(pin_q)
  );
  logic [2:0] gpio_lo_s;
  pin_sync3 #(.W(3), .INIT(3'h0)) u_sync_lo (
    .clk(clk),
    .rst_n(rst_r),
    .d(gpio_wake_in[2:0]),
    .q(gpio_lo_s)
  );
  assign {rtc_rst_n_s, rsw_n_s, pwr_s, dcd_n_s, touch_s, alarm_s, batt_inh_s, batt_low_s} = pin_q[12:5];
  assign gpio_s = {pin_q[4:0], gpio_lo_s};

  seq_state_e state_r, state_nxt;
  logic [9:0] div_r;
  logic rtc_tick;
  logic [3:0] tick_cnt_r;
  logic [3:0] hold_r;
  logic [31:0] wdog_r;
  logic [31:0] ka_r;
  logic [WAKE_GPIO_N-1:0] gpio_prev_r;
  logic gpio3_arm_r;
  logic pwr_prev_r, dcd_prev_r, touch_prev_r, alarm_prev_r;
  logic [ST_W-1:0] stat_r;
  logic [WAKE_GPIO_N-1:0] wake_en_r;

  assign rtc_tick = (div_r == 10'(RTC_DIV - 1));
  wire [WAKE_GPIO_N-1:0] gpio_rise = gpio_s & ~gpio_prev_r;
  wire gpio3_fall = gpio_prev_r[WAKE_GPIO3] & ~gpio_s[WAKE_GPIO3];
  wire [WAKE_GPIO_N-1:0] gpio_evt = (gpio_rise & wake_en_r) |
                                    ({{(WAKE_GPIO_N-1){1'b0}}, 1'b0} |
                                     (WAKE_GPIO_N'(gpio3_fall & gpio3_arm_r) << WAKE_GPIO3)); // RULE_14 RULE_15
  wire src_evt = (pwr_s & ~pwr_prev_r) | (dcd_prev_r & ~dcd_n_s) | (touch_s & ~touch_prev_r) |
                 (alarm_s & ~alarm_prev_r) | (|gpio_evt); // RULE_10
  wire wake_go = (state_r == S_OFF) && src_evt;
  wire sample_now = (state_r == S_ANNOUNCE) && rtc_tick && (tick_cnt_r == BATT_SAMPLE_TICKS - 4'h1); // RULE_18
  wire inhibit_ok = batt_inh_s & ~batt_low_s;
  wire wdog_exp = (state_r == S_RUN) && (wdog_r == 32'(WDOG_CYCLES - 1)) && !activation_watchdog_clear;
  wire ka_exp = (state_r == S_RUN) && keepalive_enable && (ka_r == 32'(KA_CYCLES - 1)) && !keepalive_counter_clear;
  wire sw_shut = (state_r == S_RUN) && software_shutdown_req && !irq_pending; // RULE_08
  wire batt_shut = (state_r == S_RUN) && batt_low_s;
  wire rsw_evt = !rsw_n_s;
  wire any_shut = wdog_exp | ka_exp | sw_shut | batt_shut; // RULE_09

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_OFF: if (wake_go) state_nxt = S_ANNOUNCE;
      S_ANNOUNCE: if (sample_now) state_nxt = inhibit_ok ? S_PERI_REL : S_SHUT; // RULE_12 RULE_13
      S_PERI_REL: if (hold_r == PERI_HOLD) state_nxt = S_CORE_REL;
      S_CORE_REL: if (hold_r == CORE_HOLD) state_nxt = S_RUN;
      S_RUN: if (any_shut) state_nxt = S_SHUT;
      S_SHUT: state_nxt = S_OFF;
      default: state_nxt = S_OFF;
    endcase
    if (rsw_evt) state_nxt = S_PERI_REL; // RULE_03
  end

  logic [ST_W-1:0] set_v;
  always_comb begin
    set_v = '0;
    set_v[ST_RESET_SWITCH] = rsw_evt;
    set_v[ST_TIMEOUT] = wdog_exp; // RULE_05
    set_v[ST_KEEPALIVE] = ka_exp; // RULE_06
    set_v[ST_BATT_INHIBIT] = (sample_now && !inhibit_ok) || batt_shut; // RULE_13
    set_v[ST_GPIO_LSB +: WAKE_GPIO_N] = gpio_evt & {WAKE_GPIO_N{state_r == S_OFF}}; // RULE_16
  end

  always_ff @(posedge clk or negedge rst_r) begin
    if (!rst_r) begin
      state_r <= S_OFF;
      div_r <= '0;
      tick_cnt_r <= '0;
      hold_r <= '0;
      wdog_r <= '0;
      ka_r <= '0;
      gpio_prev_r <= '0;
      pwr_prev_r <= 1'b0;
      dcd_prev_r <= 1'b1;
      touch_prev_r <= 1'b0;
      alarm_prev_r <= 1'b0;
      gpio3_arm_r <= 1'b1;
      stat_r <= '0;
      wake_en_r <= WAKE_EN_RESET;
    end else if (!rtc_rst_n_s) begin
      state_r <= S_PERI_REL; // RULE_01
      div_r <= '0;
      hold_r <= '0;
      gpio3_arm_r <= 1'b1;
      wake_en_r <= WAKE_EN_RESET; // RULE_15
      stat_r <= '0;
      stat_r[ST_RTC_RESET] <= 1'b1; // RULE_01
    end else begin
      state_r <= state_nxt;
      div_r <= rtc_tick ? 10'h000 : div_r + 10'h001;
      tick_cnt_r <= (state_r != S_ANNOUNCE) ? 4'h0 : (rtc_tick ? tick_cnt_r + 4'h1 : tick_cnt_r);
      hold_r <= (state_nxt != state_r) ? 4'h0 : hold_r + 4'h1;
      wdog_r <= (state_r != S_RUN || activation_watchdog_clear) ? 32'h0 : wdog_r + 32'h1;
      ka_r <= (state_r != S_RUN || !keepalive_enable || keepalive_counter_clear) ? 32'h0 : ka_r + 32'h1;
      gpio_prev_r <= gpio_s;
      pwr_prev_r <= pwr_s;
      dcd_prev_r <= dcd_n_s;
      touch_prev_r <= touch_s;
      alarm_prev_r <= alarm_s;
      if (wake_enable_we) gpio3_arm_r <= 1'b0;
      if (wake_enable_we) wake_en_r <= wake_enable_wdata;
      stat_r <= (stat_r & ~status_clear) | set_v; // RULE_02
    end
  end

  always_ff @(posedge clk or negedge rst_r) begin
    if (!rst_r) begin
      power_on_indication <= 1'b0;
      main_power_enable_out <= 1'b0;
      rtc_reset_out <= 1'b1;
      peripheral_reset_out <= 1'b1;
      core_cold_reset_out <= 1'b1;
      core_reset_out <= 1'b1;
      cpu_clock_stop <= 1'b1;
      wake_enable <= WAKE_EN_RESET;
      power_status_register <= '0;
    end else begin
      power_on_indication <= (state_nxt == S_ANNOUNCE); // RULE_11
      main_power_enable_out <= (state_nxt == S_PERI_REL) || (state_nxt == S_CORE_REL) || (state_nxt == S_RUN);
      rtc_reset_out <= !rtc_rst_n_s; // RULE_01
      peripheral_reset_out <= !rtc_rst_n_s || !((state_nxt == S_CORE_REL) || (state_nxt == S_RUN)); // RULE_12
      core_cold_reset_out <= !rtc_rst_n_s || (state_nxt != S_RUN); // RULE_09
      core_reset_out <= !rtc_rst_n_s || (state_nxt != S_RUN);
      cpu_clock_stop <= (state_nxt != S_RUN); // RULE_08
      wake_enable <= wake_en_r;
      power_status_register <= stat_r;
      power_status_register[ST_CARRIER] <= !dcd_n_s; // RULE_17
    end
  end

  sequence flag_then_cold_s(flag);
    flag ##1 core_cold_reset_out;
  endsequence

  chk_sample_brackets: assert property (@(posedge clk) disable iff (!rst_r)
    sample_now |=> !power_on_indication) else $error("indication not dropped after sample"); // RULE_11
  chk_batt_block: assert property (@(posedge clk) disable iff (!rst_r)
    (sample_now && !inhibit_ok && rtc_rst_n_s) |=> stat_r[ST_BATT_INHIBIT]) else $error("inhibit flag missing"); // RULE_13
  chk_core_after_peri: assert property (@(posedge clk) disable iff (!rst_r)
    $fell(core_cold_reset_out) |-> !peripheral_reset_out) else $error("core released before peripherals"); // RULE_12
  chk_wdog_flag: assert property (@(posedge clk) disable iff (!rst_r)
    (wdog_exp && rtc_rst_n_s) |=> stat_r[ST_TIMEOUT]) else $error("timeout flag missing"); // RULE_05
  chk_ka_flag: assert property (@(posedge clk) disable iff (!rst_r)
    (ka_exp && rtc_rst_n_s) |=> flag_then_cold_s(stat_r[ST_KEEPALIVE])) else $error("keep-alive shutdown"); // RULE_06
  chk_sleep_gate: assert property (@(posedge clk) disable iff (!rst_r)
    (state_r == S_RUN && irq_pending && !wdog_exp && !ka_exp && !batt_shut && !rsw_evt && rtc_rst_n_s)
    |=> state_r == S_RUN) else $error("slept with pending interrupt"); // RULE_08
  chk_rtc_reset: assert property (@(posedge clk) disable iff (!rst_r)
    !rtc_rst_n_s |=> stat_r[ST_RTC_RESET] && wake_en_r == WAKE_EN_RESET) else $error("rtc reset effect missing"); // RULE_01
  chk_rsw_flag: assert property (@(posedge clk) disable iff (!rst_r)
    (rsw_evt && rtc_rst_n_s) |=> flag_then_cold_s(stat_r[ST_RESET_SWITCH])) else $error("reset switch"); // RULE_03
  chk_flag_hold: assert property (@(posedge clk) disable iff (!rst_r)
    (stat_r[ST_TIMEOUT] && !status_clear[ST_TIMEOUT] && rtc_rst_n_s) |=> stat_r[ST_TIMEOUT]) else $error("flag lost"); // RULE_02
  chk_gpio_flag: assert property (@(posedge clk) disable iff (!rst_r)
    (state_r == S_OFF && (|gpio_evt) && rtc_rst_n_s)
    |=> ((stat_r[ST_GPIO_LSB +: WAKE_GPIO_N] & $past(gpio_evt)) == $past(gpio_evt))) else $error("gpio flag missing"); // RULE_16
  chk_wake_gate: assert property (@(posedge clk) disable iff (!rst_r)
    (state_r == S_OFF && rtc_rst_n_s && !rsw_evt && !gpio3_arm_r && !(pwr_s & ~pwr_prev_r) && (dcd_n_s | ~dcd_prev_r)
     && !(touch_s & ~touch_prev_r) && !(alarm_s & ~alarm_prev_r) && ((gpio_s & ~gpio_prev_r & wake_en_r) == '0))
    |=> !power_on_indication) else $error("disabled gpio woke"); // RULE_14
  chk_carrier: assert property (@(posedge clk) disable iff (!rst_r)
    ##1 power_status_register[ST_CARRIER] == !$past(dcd_n_s)) else $error("carrier bit wrong"); // RULE_17
endmodule : power_reset_wake_sequencer

/* File: sim/pwr_supply_model.sv */
// External supply model: battery level and power-on announcement counter
`timescale 1ns/100ps
module pwr_supply_model (
  input wire logic clk,
  input wire logic power_on_indication,
  input wire logic batt_good,
  output logic battery_inhibit_in,
  output logic [7:0] announce_cnt
);
  logic ind_q = 1'b0;
  initial battery_inhibit_in = 1'b0;
  initial announce_cnt = 8'h00;
  // Level only valid while announced; show the opposite otherwise
  always @(negedge clk) begin
    battery_inhibit_in <= power_on_indication ? batt_good : !batt_good;
    ind_q <= power_on_indication;
    if (power_on_indication && !ind_q) announce_cnt <= announce_cnt + 8'h01;
  end
endmodule : pwr_supply_model

/* File: sim/power_reset_wake_sequencer_tb_top.sv */
// Self-checking bench for the power, reset and wake sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
`define WAITFOR(c, l) for (int k = 0; k < (l) && !(c); k++) @(negedge clk);
module power_reset_wake_sequencer_tb_top import pwr_seq_pkg::*;;
  localparam int WD = 2000;
  localparam int KA = 100;
  logic clk = 0, nrst = 0, rtc_n = 1, rsw_n = 1, pwr = 0, cd_n = 1, touch = 0, alarm = 0;
  logic blow = 0, we = 0, wdc = 0, kae = 0, kac = 0, sdr = 0, irq = 0, good = 1, bi, st5;
  logic ind, mpe, rtco, perio, ccro, cro, cstop;
  logic [7:0] gw = '0, wd_data = '0, wen, ann;
  logic [15:0] sclr = '0, st, sr;
  int miscompares = 0, n_tests = 0, cyc = 0, nw = 0, b;
  initial forever #20 clk = !clk;
  power_reset_wake_sequencer #(.WDOG_CYCLES(WD), .KA_CYCLES(KA)) i_dut (.clk(clk), .nrst(nrst),
    .rtc_reset_in_n(rtc_n), .reset_switch_in_n(rsw_n), .power_switch_in(pwr), .gpio_wake_in(gw),
    .carrier_detect_in_n(cd_n), .touch_wake_in(touch), .alarm_wake_in(alarm), .battery_inhibit_in(bi),
    .battery_low_in(blow), .wake_enable_wdata(wd_data), .wake_enable_we(we), .activation_watchdog_clear(wdc),
    .keepalive_enable(kae), .keepalive_counter_clear(kac), .software_shutdown_req(sdr), .irq_pending(irq),
    .status_clear(sclr), .power_on_indication(ind), .main_power_enable_out(mpe), .rtc_reset_out(rtco),
    .peripheral_reset_out(perio), .core_cold_reset_out(ccro), .core_reset_out(cro), .cpu_clock_stop(cstop),
    .wake_enable(wen), .power_status_register(sr));
  pwr_supply_model i_sup (.clk(clk), .power_on_indication(ind), .batt_good(good), .battery_inhibit_in(bi),
    .announce_cnt(ann));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic clr(input logic [15:0] m);
    sclr = m;
    tick(1);
    sclr = '0;
    // Status output lags the flag by one register stage
    tick(1);
  endtask : clr
  task automatic wake(input int src, input logic g, input logic go, input logic wclr);
    int cnt;
    cnt = 0;
    good = g;
    nw++;
    case (src)
      0: pwr = 1;
      1: touch = 1;
      2: alarm = 1;
      11: cd_n = 0;
      default: gw[src-3] = 1;
    endcase
    `WAITFOR(ind === 1'b1, 12)
    `CHK("ind_rise", 1'b1, ind)
    {pwr, touch, alarm, gw} = '0;
    cd_n = 1;
    while (ind === 1'b1 && cnt < 4000) begin
      cnt++;
      tick(1);
    end
    `CHK("ind_len", 1'b1, cnt > 3 * RTC_DIV && cnt <= 4 * RTC_DIV + 4)
    `WAITFOR(perio === 1'b0, 12)
    `CHK("peri_rel", !go, perio)
    `CHK("core_late", 1'b1, cro)
    tick(int'(CORE_HOLD) + 2);
    `CHK("core_run", !go, ccro)
    `CHK("main_pwr", go, mpe)
    `CHK("batt_flag", !g || blow, sr[ST_BATT_INHIBIT])
    wdc = wclr;
    tick(1);
    wdc = 0;
  endtask : wake
  task automatic sleep_chk();
    irq = 1;
    sdr = 1;
    tick(20);
    `CHK("sleep_refused", 1'b0, cstop)
    st = sr;
    irq = 0;
    `WAITFOR(cstop === 1'b1, 20)
    `CHK("clk_stop", 1'b1, cstop)
    `CHK("sleep_peri", 1'b1, perio)
    `CHK("sleep_rtc", 1'b0, rtco)
    `CHK("sleep_mpe", 1'b0, mpe)
    `CHK("sleep_status", st, sr)
    sdr = 0;
    tick(20);
  endtask : sleep_chk
  initial begin
    b = $urandom(76102);
    tick(20);
    `CHK("rst_core", 1'b1, ccro)
    `CHK("rst_status", 16'h0000, sr)
    nrst = 1;
    tick(10 + $urandom % 8);
    for (int s = 0; s < 3; s++) begin
      wake(s, 1, 1, 1);
      sleep_chk();
    end
    wake(0, 0, 0, 0);
    clr(16'h0001 << ST_BATT_INHIBIT);
    `CHK("batt_clr", 1'b0, sr[ST_BATT_INHIBIT])
    blow = 1;
    wake(1, 1, 0, 0);
    blow = 0;
    clr(16'h0001 << ST_BATT_INHIBIT);
    b = $urandom % 8;
    we = 1;
    tick(1);
    we = 0;
    gw[b] = 1;
    tick(20);
    `CHK("gpio_off", 1'b0, ind)
    gw = '0;
    wd_data = 8'h01 << b;
    we = 1;
    tick(1);
    we = 0;
    tick(10);
    `CHK("wake_en", wd_data, wen)
    wake(3 + b, 0, 0, 0);
    `CHK("gpio_flag", 1'b1, sr[ST_GPIO_LSB+b])
    clr(16'h0001 << ST_BATT_INHIBIT);
    wake(3 + b, 1, 1, 1);
    st5 = sr[ST_CARRIER];
    cd_n = 0;
    tick(8);
    `CHK("carrier_lvl", !st5, sr[ST_CARRIER])
    cd_n = 1;
    tick(8);
    `CHK("carrier_back", st5, sr[ST_CARRIER])
    sleep_chk();
    wake(11, 1, 1, 1);
    blow = 1;
    tick(8);
    `CHK("blow_shut", 1'b1, ccro)
    `CHK("blow_flag", 1'b1, sr[ST_BATT_INHIBIT])
    blow = 0;
    clr(16'h0001 << ST_BATT_INHIBIT);
    wake(0, 1, 1, 0);
    tick(WD + 50);
    `CHK("wdog_flag", 1'b1, sr[ST_TIMEOUT])
    clr(16'h0001 << ST_TIMEOUT);
    `CHK("wdog_clr", 1'b0, sr[ST_TIMEOUT])
    rsw_n = 0;
    tick(10);
    `CHK("rsw_core", 1'b1, ccro)
    `CHK("rsw_rtc", 1'b0, rtco)
    `CHK("rsw_flag", 1'b1, sr[ST_RESET_SWITCH])
    rsw_n = 1;
    `WAITFOR(cro === 1'b0, 200)
    `CHK("rsw_run", 1'b0, cro)
    wdc = 1;
    tick(1);
    wdc = 0;
    kae = 1;
    repeat (3) begin
      tick(KA / 2);
      kac = 1;
      tick(1);
      kac = 0;
    end
    `CHK("ka_kept", 1'b0, sr[ST_KEEPALIVE])
    tick(KA + 20);
    `CHK("ka_flag", 1'b1, sr[ST_KEEPALIVE])
    kae = 0;
    rtc_n = 0;
    tick(10);
    `CHK("rtc_out", 1'b1, rtco)
    `CHK("rtc_core", 1'b1, cro)
    rtc_n = 1;
    tick(10);
    `CHK("rtc_flag", 1'b1, sr[ST_RTC_RESET])
    `CHK("rtc_en", WAKE_EN_RESET, wen)
    // Sleep again, then line three must wake on its falling edge only
    sdr = 1;
    tick(40);
    sdr = 0;
    gw[WAKE_GPIO3] = 1;
    tick(10);
    `CHK("g3_rise", 1'b0, ind)
    gw[WAKE_GPIO3] = 0;
    nw++;
    `WAITFOR(ind === 1'b1, 12)
    `CHK("g3_fall", 1'b1, ind)
    tick(1);
    `CHK("g3_flag", 1'b1, sr[ST_GPIO_LSB+WAKE_GPIO3])
    `CHK("announce", nw[7:0], ann)
    tally_and_finish();
  end
endmodule : power_reset_wake_sequencer_tb_top
